//--- rtl/status_pkg.sv
// constants, commands and carrier types of the status event aggregator
package status_pkg;
  // bit positions of the standard event register
  localparam int POWER_ON_BIT   = 7;
  localparam int CMD_ERR_BIT    = 5;
  localparam int EXEC_ERR_BIT   = 4;
  localparam int QUERY_ERR_BIT  = 2;
  localparam int OP_DONE_BIT    = 0;
  // bit positions of the status byte
  localparam int OP_SUM_BIT     = 7;
  localparam int MASTER_SUM_BIT = 6;
  localparam int STD_SUM_BIT    = 5;
  localparam int MSG_AVAIL_BIT  = 4;
  // writable and readable bits per register
  localparam logic [7:0] STD_USED_MASK = 8'hB5;
  localparam logic [7:0] OP_USED_MASK  = 8'hFF;
  localparam logic [7:0] SRQ_USED_MASK = 8'hB0;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // decimal weights of the response digits
  localparam int DEC_HUNDRED = 100;
  localparam int DEC_TEN     = 10;

  // commands decoded upstream by the parser
  typedef enum logic [3:0] {
    std_mask_write, std_mask_query, std_flags_read_clear,
    op_enable_write_cmd, op_mask_query, op_event_read_clear_query,
    op_condition_query, srq_mask_write, srq_mask_query,
    status_byte_query, clear_status, op_done_arm, serial_poll
  } cmd_code_t;

  // one command with its decimal parameter already in binary
  typedef struct packed {
    cmd_code_t  code;
    logic [7:0] value;
  } cmd_t;

  // live operation state, bit 7 down to bit 0
  typedef struct packed {
    logic processor_link_error;
    logic trim_data_fault;
    logic autotuner_idle;
    logic fresh_reading;
    logic loop1_slope_done;
    logic loop2_slope_done;
    logic input_overrange;
    logic input_alarm;
  } op_cond_t;

  // decimal digits of a response
  typedef struct packed {
    logic [3:0] hundreds;
    logic [3:0] tens;
    logic [3:0] ones;
  } dec_t;
endpackage

//--- rtl/status_event_aggregator.sv
// status registers, summary bits and service request of the remote port
`timescale 1ns/1ps

module status_event_aggregator (
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic               cmd_valid,
  input  wire status_pkg::cmd_t   cmd,
  input  wire logic               cmd_error,
  input  wire logic               exec_error,
  input  wire logic               query_error,
  input  wire logic               ops_pending,
  input  wire logic               msg_available,
  input  wire status_pkg::op_cond_t op_cond_pin,
  input  wire logic               alarm_visible_pin,
  output logic                    resp_valid,
  output logic [7:0]              resp_value,
  output status_pkg::dec_t        resp_decimal,
  output logic                    service_request
);
  import status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // binary to three decimal digits
  function automatic dec_t to_decimal(input logic [7:0] v);
    dec_t d;
    d.hundreds = 4'(v / DEC_HUNDRED);
    d.tens     = 4'((v % DEC_HUNDRED) / DEC_TEN);
    d.ones     = 4'(v % DEC_TEN);
    return d;
  endfunction

  // or of event and enable products
  function automatic logic summary(input logic [7:0] ev,
                                   input logic [7:0] en);
    return |(ev & en);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [8:0] sync1;           // first stage, read by sync2 only
  logic [8:0] sync2;           // second stage
  logic [8:0] sync3;           // third stage
  logic [8:0] live;            // filtered pin state
  logic [7:0] op_live;         // operation condition register
  logic [7:0] op_live_q;       // previous condition, for rise detect
  logic [7:0] std_flags;       // standard event register
  logic [7:0] std_mask;        // standard event enable
  logic [7:0] op_flags;        // operation event register
  logic [7:0] op_mask;         // operation event enable
  logic [7:0] srq_mask;        // service request enable
  logic [7:0] std_set;         // standard events this cycle
  logic [7:0] op_set;          // operation events this cycle
  logic [7:0] status_byte;     // live status byte, master summary in
  logic       std_clr;         // standard register cleared this cycle
  logic       op_clr;          // operation register cleared this cycle
  logic       master_sum;      // master summary
  logic       master_sum_q;    // previous master summary
  logic       rqs;             // request service flag
  logic       pon_pending;     // power-on event not yet logged
  logic       op_done_armed;   // completion command seen
  logic       is_cmd;          // shorthand for a command this cycle
  logic [7:0] next_resp_value; // answer byte of this command
  logic       next_resp_valid; // this command is a query

  assign is_cmd = cmd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // three stages; a change counts once stages two and three agree,
  // so a single metastable sample never reaches the registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      live  <= '0;
    end else begin
      sync1 <= {alarm_visible_pin, op_cond_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      live  <= (sync2 & sync3) | (live & (sync2 ^ sync3));
    end
  end

  // alarm only shows while the alarm is set visible
  always_comb begin
    op_live    = live[7:0];
    op_live[0] = live[0] & live[8];
  end

  // previous condition, so an event is its rising edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_live_q <= REG_RESET;
    end else begin
      op_live_q <= op_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event sources

  // standard events; power-on logs once after reset release
  always_comb begin
    std_set                = '0;
    std_set[POWER_ON_BIT]  = pon_pending;
    std_set[CMD_ERR_BIT]   = cmd_error;
    std_set[EXEC_ERR_BIT]  = exec_error;
    std_set[QUERY_ERR_BIT] = query_error;
    std_set[OP_DONE_BIT]   = op_done_armed & ~ops_pending;
    op_set                 = op_live & ~op_live_q;
  end

  // a pending flag rather than a strap, so reset holds constants only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pon_pending <= 1'b1;
    end else begin
      pon_pending <= 1'b0;
    end
  end

  // completion arm; the completion query never reaches this block
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_done_armed <= 1'b0;
    end else if (is_cmd && cmd.code == op_done_arm) begin
      op_done_armed <= 1'b1;
    end else if (std_set[OP_DONE_BIT] ||
                 (is_cmd && cmd.code == clear_status)) begin
      op_done_armed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event registers

  assign std_clr = is_cmd && (cmd.code == std_flags_read_clear ||
                              cmd.code == clear_status);
  assign op_clr  = is_cmd && (cmd.code == op_event_read_clear_query ||
                              cmd.code == clear_status);

  // sticky bits; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      std_flags <= REG_RESET;
    end else begin
      std_flags <= ((std_clr ? REG_RESET : std_flags) | std_set)
                   & STD_USED_MASK;
    end
  end

  // operation events latch rising conditions the same way
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_flags <= REG_RESET;
    end else begin
      op_flags <= ((op_clr ? REG_RESET : op_flags) | op_set)
                  & OP_USED_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable registers, the only writable ones

  // whole-mask writes; unused bits are dropped on entry
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      std_mask <= REG_RESET;
      op_mask  <= REG_RESET;
      srq_mask <= REG_RESET;
    end else if (is_cmd) begin
      case (cmd.code)
        std_mask_write:
          std_mask <= cmd.value & STD_USED_MASK;
        op_enable_write_cmd:
          op_mask <= cmd.value & OP_USED_MASK;
        srq_mask_write:
          srq_mask <= cmd.value & SRQ_USED_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status byte and service request

  // summaries are combinational, nothing here latches
  always_comb begin
    status_byte                 = '0;
    status_byte[OP_SUM_BIT]     = summary(op_flags, op_mask);
    status_byte[STD_SUM_BIT]    = summary(std_flags, std_mask);
    status_byte[MSG_AVAIL_BIT]  = msg_available;
    master_sum                  = summary(status_byte, srq_mask);
    status_byte[MASTER_SUM_BIT] = master_sum;
  end

  // request rises with the master summary; rise wins over a poll
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_sum_q <= 1'b0;
      rqs          <= 1'b0;
    end else begin
      master_sum_q <= master_sum;
      if (master_sum && !master_sum_q) begin
        rqs <= 1'b1;
      end else if (is_cmd && cmd.code == serial_poll) begin
        rqs <= 1'b0;
      end
    end
  end

  assign service_request = rqs;

  ////////////////////////////////////////////////////////////////////////////
  // query answers

  // pick the answer; writes, clear and arm give none
  always_comb begin
    next_resp_value = REG_RESET;
    next_resp_valid = is_cmd;
    case (cmd.code)
      std_mask_query:            next_resp_value = std_mask;
      std_flags_read_clear:      next_resp_value = std_flags;
      op_mask_query:             next_resp_value = op_mask;
      op_event_read_clear_query: next_resp_value = op_flags;
      op_condition_query:        next_resp_value = op_live;
      srq_mask_query:            next_resp_value = srq_mask;
      status_byte_query:         next_resp_value = status_byte;
      serial_poll: begin
        next_resp_value                 = status_byte;
        next_resp_value[MASTER_SUM_BIT] = rqs;
      end
      default:                   next_resp_valid = 1'b0;
    endcase
  end

  // answer one cycle after the command, value and decimal digits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid   <= 1'b0;
      resp_value   <= REG_RESET;
      resp_decimal <= '0;
    end else begin
      resp_valid <= next_resp_valid;
      if (next_resp_valid) begin
        resp_value   <= next_resp_value;
        resp_decimal <= to_decimal(next_resp_value);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  decimal_sum_a: assert property (resp_valid |->
    resp_decimal.hundreds * DEC_HUNDRED + resp_decimal.tens * DEC_TEN +
    resp_decimal.ones == resp_value)
    else $error("decimal digits differ from value");
  read_clear_a: assert property (
    is_cmd && cmd.code == std_flags_read_clear |=>
    resp_value == $past(std_flags) && std_flags == $past(std_set))
    else $error("standard read did not return and clear");
  clear_both_a: assert property (
    is_cmd && cmd.code == clear_status |=>
    std_flags == $past(std_set) && op_flags == $past(op_set))
    else $error("clear status left event bits");
  mask_write_a: assert property (
    is_cmd && cmd.code == std_mask_write |=>
    std_mask == ($past(cmd.value) & STD_USED_MASK))
    else $error("standard mask write lost");
  flag_latch_a: assert property (!std_clr |=>
    (std_flags & $past(std_flags)) == $past(std_flags))
    else $error("standard flag dropped without clear");
  std_summary_a: assert property (
    status_byte[STD_SUM_BIT] == |(std_flags & std_mask))
    else $error("standard summary wrong");
  master_sum_a: assert property (
    status_byte[MASTER_SUM_BIT] ==
    |(status_byte & srq_mask & SRQ_USED_MASK))
    else $error("master summary wrong");
  request_rise_a: assert property ($rose(master_sum) |=> rqs)
    else $error("no request on master summary rise");
  poll_clear_a: assert property (
    is_cmd && cmd.code == serial_poll && !$rose(master_sum) |=> !rqs)
    else $error("serial poll left the request set");
  op_done_a: assert property (
    op_done_armed && !ops_pending |=> std_flags[OP_DONE_BIT])
    else $error("completion bit not set");
  cond_follow_a: assert property (
    sync2 == sync3 |=> live == $past(sync3))
    else $error("condition did not follow pins");

  cmd_err_srq_c: cover property (
    $rose(std_flags[CMD_ERR_BIT]) ##[1:4] rqs);
  poll_clear_c: cover property (
    rqs && is_cmd && cmd.code == serial_poll ##1 !rqs && master_sum);
  op_event_c: cover property ($rose(status_byte[OP_SUM_BIT]));
  set_clear_c: cover property (std_clr && |std_set);
endmodule // status_event_aggregator

//--- verif/host_model.sv
// bus controller model that issues commands and collects the answers
`timescale 1ns/1ps

module host_model (
  input  wire logic             ref_clk,
  input  wire logic             resp_valid,
  input  wire logic [7:0]       resp_value,
  input  wire status_pkg::dec_t resp_decimal,
  output status_pkg::cmd_t      cmd,
  output logic                  cmd_valid
);
  import status_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one command, entered just after an edge; the answer is taken in the
  // cycle after the taking edge, where the registered pulse stands
  task automatic xfer(input cmd_code_t code, input logic [7:0] value,
                      output logic [7:0] v, output dec_t d,
                      output logic ok);
    cmd_valid = 1'b1;
    cmd       = '{code: code, value: value};
    @(posedge ref_clk);
    #1;
    ok        = resp_valid;
    v         = resp_value;
    d         = resp_decimal;
    cmd_valid = 1'b0;
    // a released bus shows garbage, never a stale copy
    cmd       = ~cmd;
    // one idle edge so the strobe is never raised at the edge it fell
    @(posedge ref_clk);
    #1;
  endtask
endmodule // host_model

//--- verif/testbench.sv
// self-checking bench of the status event aggregator
`timescale 1ns/1ps

module testbench;
  import status_pkg::*;

  logic       ref_clk;
  logic       arst_n;
  logic       cmd_valid;
  logic       cmd_error;
  logic       exec_error;
  logic       query_error;
  logic       ops_pending;
  logic       msg_available;
  logic       alarm_visible_pin;
  logic       resp_valid;
  logic       service_request;
  logic [7:0] resp_value;
  cmd_t       cmd;
  dec_t       resp_decimal;
  op_cond_t   op_cond_pin;
  int         fails;
  int         comparisons;

  status_event_aggregator status_event_aggregator_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_error(cmd_error), .exec_error(exec_error),
    .query_error(query_error), .ops_pending(ops_pending),
    .msg_available(msg_available), .op_cond_pin(op_cond_pin),
    .alarm_visible_pin(alarm_visible_pin), .resp_valid(resp_valid),
    .resp_value(resp_value), .resp_decimal(resp_decimal),
    .service_request(service_request));

  host_model host_model_i (
    .ref_clk(ref_clk), .resp_valid(resp_valid),
    .resp_value(resp_value), .resp_decimal(resp_decimal),
    .cmd(cmd), .cmd_valid(cmd_valid));

  ////////////////////////////////////////////////////////////////////////
  // compare tasks, one per kind of result
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_dec(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // helpers: a write, a judged query, a wait of whole cycles
  task automatic put(input cmd_code_t code, input logic [7:0] value);
    logic [7:0] v;
    dec_t       d;
    logic       ok;
    host_model_i.xfer(code, value, v, d, ok);
  endtask

  task automatic ask(input cmd_code_t code, input logic [7:0] exp);
    logic [7:0] v;
    dec_t       d;
    logic       ok;
    host_model_i.xfer(code, 8'h00, v, d, ok);
    check_bit(ok, 1'b1);
    check_byte(v, exp);
    check_dec(d, {4'(exp / 100), 4'((exp / 10) % 10), 4'(exp % 10)});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic power_up;
    ask(std_flags_read_clear, 8'h80);
    ask(std_flags_read_clear, 8'h00);
    ask(std_mask_query, 8'h00);
    ask(op_mask_query, 8'h00);
    ask(srq_mask_query, 8'h00);
    ask(status_byte_query, 8'h00);
  endtask

  task automatic std_events;
    put(std_mask_write, 8'hFF);
    ask(std_mask_query, 8'hB5);
    {cmd_error, exec_error, query_error} = 3'b111;
    cycles(1);
    {cmd_error, exec_error, query_error} = 3'b000;
    ask(status_byte_query, 8'h20);
    put(srq_mask_write, 8'hFF);
    ask(srq_mask_query, 8'hB0);
    check_bit(service_request, 1'b1);
    ask(status_byte_query, 8'h60);
    ask(serial_poll, 8'h60);
    check_bit(service_request, 1'b0);
    ask(status_byte_query, 8'h60);
    ask(std_flags_read_clear, 8'h34);
    ask(status_byte_query, 8'h00);
    put(srq_mask_write, 8'h00);
    put(std_mask_write, 8'h00);
    ask(std_mask_query, 8'h00);
  endtask

  task automatic op_events;
    op_cond_pin = 8'hFF;
    cycles(6);
    ask(op_condition_query, 8'hFE);
    alarm_visible_pin = 1'b1;
    cycles(6);
    ask(op_condition_query, 8'hFF);
    ask(op_event_read_clear_query, 8'hFF);
    ask(op_event_read_clear_query, 8'h00);
    op_cond_pin = 8'h00;
    cycles(6);
    ask(op_condition_query, 8'h00);
    put(op_enable_write_cmd, 8'h10);
    ask(op_mask_query, 8'h10);
    op_cond_pin = 8'h10;
    cycles(6);
    ask(status_byte_query, 8'h80);
    put(clear_status, 8'h00);
    ask(status_byte_query, 8'h00);
  endtask

  task automatic completion;
    ops_pending = 1'b1;
    put(op_done_arm, 8'h00);
    cycles(4);
    ask(std_flags_read_clear, 8'h00);
    ops_pending = 1'b0;
    cycles(2);
    ask(std_flags_read_clear, 8'h01);
    msg_available = 1'b1;
    cycles(1);
    ask(status_byte_query, 8'h10);
    msg_available = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict, the single end of the run
  task automatic test_done;
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // free-running clock, 10 ns period
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // main sequence
  initial begin
    fails             = 0;
    comparisons       = 0;
    arst_n            = 1'b0;
    {cmd_error, exec_error, query_error} = 3'b000;
    ops_pending       = 1'b0;
    msg_available     = 1'b0;
    alarm_visible_pin = 1'b0;
    op_cond_pin       = 8'h00;
    repeat (20) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    cycles(3);
    power_up();
    std_events();
    op_events();
    completion();
    test_done();
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule // testbench
